// ### inc/ccr_pkg.sv
package ccr_pkg;
    localparam logic [6:0] CCR_I2C_ADDR = 7'h6b;
    localparam logic [7:0] CCR_OFS_INPUT_SOURCE_CONTROL = 8'h00;
    localparam logic [7:0] CCR_OFS_BOOST_TEMP = 8'h01;
    localparam logic [7:0] CCR_OFS_ADC_DETECT = 8'h02;
    localparam logic [7:0] CCR_OFS_CHARGE_BOOST_WD = 8'h03;
    localparam logic [7:0] CCR_OFS_LAST = 8'h03;
    localparam logic [7:0] CCR_RST_REG0 = 8'h08;
    localparam logic [7:0] CCR_RST_REG1 = 8'h06;
    localparam logic [7:0] CCR_RST_REG2 = 8'h11;
    localparam logic [7:0] CCR_RST_REG3 = 8'h1a;
    // reg0 fields
    localparam int CCR_B_HIZ = 7;
    localparam int CCR_B_LIM_PIN = 6;
    localparam logic [5:0] CCR_LIM_500MA = 6'h08;
    localparam logic [5:0] CCR_LIM_3250MA = 6'h3f;
    // reg1 fields
    localparam int CCR_B_COLD_THR = 5;
    localparam logic [1:0] CCR_HOT_THR_OFF = 2'h3;
    // reg2 fields
    localparam int CCR_B_ADC_GO = 7;
    localparam int CCR_B_ADC_RATE = 6;
    localparam int CCR_B_BOOST_FSEL = 5;
    localparam int CCR_B_ICO = 4;
    localparam int CCR_B_FORCE_DET = 1;
    localparam int CCR_B_AUTO_DET = 0;
    // reg3 fields
    localparam int CCR_B_BAT_LOAD = 7;
    localparam int CCR_B_WD_KICK = 6;
    localparam int CCR_B_BOOST_EN = 5;
    localparam int CCR_B_CHG_EN = 4;
    localparam int CCR_B_MIN_VBAT = 0;
    // bits that survive watchdog expiry, per register
    localparam logic [7:0] CCR_WD_KEEP0 = 8'h3f;
    localparam logic [7:0] CCR_WD_KEEP1 = 8'h1f;
    localparam logic [7:0] CCR_WD_KEEP2 = 8'h1d;
    localparam logic [7:0] CCR_WD_KEEP3 = 8'h0e;
    // input voltage limit in mV
    localparam logic [15:0] CCR_VIN_MIN_MV = 16'd3900;
    localparam logic [15:0] CCR_VIN_MAX_MV = 16'd15300;
    localparam logic [15:0] CCR_OFS_LSB_MV = 16'd100;
    localparam int CCR_ADC_PERIOD_MS = 1000;
    localparam int CCR_CLK_KHZ = 100000;
    localparam int CCR_ADC_PERIOD_CYC = CCR_ADC_PERIOD_MS * CCR_CLK_KHZ;
    typedef enum logic [1:0] {
        CCR_ST_ADDR = 2'b00,
        CCR_ST_REG = 2'b01,
        CCR_ST_DATA = 2'b11,
        CCR_ST_IGNORE = 2'b10
    } ccr_state_t;
endpackage

// ### rtl/ccr_regs.sv
// Function
// - slave answers at 7-bit address 0x6b plus direction bit
// - 6-bit input current limit, 50 mA steps from 100 mA, register reset only
// - with pin enabled, applied limit is lower of register and pin limit
// - detection done loads 500 mA if select high, 3.25 A if low
// - reg0 bit7 high impedance, bit6 limit pin enable, watchdog resets both
// - 2-bit boost hot threshold, code 11 disables boost thermal protection
// - 1-bit boost cold threshold, 77% or 80%, watchdog resets it
// - 5-bit input voltage offset, 100 mV lsb, default 600 mV
// - computed input voltage threshold clamped between 3.9 V and 15.3 V
// - above 6 V unloaded, offset doubled; otherwise used as is
// - writing 1 starts conversion; bit read-only in continuous rate
// - start bit stays 1 during conversion or detection, then clears
// - rate bit 0 one-shot, 1 continuous every 1 s
// - boost frequency bit writes ignored while boost enabled
// - optimizer enable defaults 1, reg2 bits 3:2 reserved default 0
// - writing 1 to force-detection starts source detection
// - auto detection enabled runs detection on power plug-in
// - watchdog kick restarts timer and self-clears; host kicks periodically
// - reg3 bit5 boost output enable, bit7 battery load, watchdog reset
// - reg3 bit4 charge enable, default 1, watchdog reset
// - 3-bit minimum system voltage, 0.1 V steps from 3.0 V, default 101
// - minimum battery bit selects boost exit level 2.9 V or 2.5 V
// - watchdog expiry restores defaults except limit fields, minimum system voltage, reg2 bits 4:2 and auto detection enable
module ccr_regs
    import ccr_pkg::*;
#(
    parameter int ADC_PERIOD_CYC = CCR_ADC_PERIOD_CYC
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic register_reset,
    input wire logic watchdog_expired,
    input wire logic source_select,
    input wire logic power_plugged,
    input wire logic detection_done,
    input wire logic adc_done,
    input wire logic [5:0] current_limit_pin,
    input wire logic input_above_6v,
    input wire logic [15:0] input_voltage_base_mv,
    output logic watchdog_restart,
    output logic detection_start,
    output logic adc_start,
    output logic high_impedance_enable,
    output logic [5:0] applied_current_limit,
    output logic [1:0] boost_hot_threshold,
    output logic boost_thermal_protect,
    output logic boost_cold_threshold,
    output logic [15:0] input_voltage_limit_mv,
    output logic adc_conversion_rate,
    output logic boost_frequency_select,
    output logic current_optimizer_enable,
    output logic auto_source_detection_enable,
    output logic battery_load_enable,
    output logic boost_output_enable,
    output logic charge_enable,
    output logic [2:0] minimum_system_voltage,
    output logic min_battery_select
);
    if (ADC_PERIOD_CYC < 2)
    begin
        $error("adc period too short");
    end

    logic [7:0] r0_reg, r1_reg, r2_reg, r3_reg;
    logic scl_q_reg, sda_q_reg;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    ccr_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic rw_reg, ack_phase_reg, nack_reg;
    logic [7:0] ptr_reg;
    logic wr_strobe;
    logic [7:0] wr_data;
    logic det_busy_reg, adc_busy_reg;
    logic [31:0] rate_cnt_reg;
    logic plug_q_reg;
    logic [15:0] vin_raw;
    logic [7:0] rd_byte;

    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        case (a)
            CCR_OFS_INPUT_SOURCE_CONTROL: rd_mux = r0_reg;
            CCR_OFS_BOOST_TEMP: rd_mux = r1_reg;
            CCR_OFS_ADC_DETECT: rd_mux = r2_reg;
            CCR_OFS_CHARGE_BOOST_WD: rd_mux = r3_reg;
            default: rd_mux = 8'hff;
        endcase
    endfunction
    assign rd_byte = rd_mux(state_reg == CCR_ST_ADDR ? ptr_reg
        : ptr_reg + 8'h1);

    // bus lines sampled once; edge seen against previous sample
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end
        else
        begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
        end
    end
    assign scl_rise = scl_in && !scl_q_reg;
    assign scl_fall = !scl_in && scl_q_reg;
    assign start_cond = scl_in && scl_q_reg && sda_q_reg && !sda_in;
    assign stop_cond = scl_in && scl_q_reg && !sda_q_reg && sda_in;

    // byte engine: data sampled on scl rise, driven after scl fall
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_reg <= CCR_ST_IGNORE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rw_reg <= 1'b0;
            ack_phase_reg <= 1'b0;
            nack_reg <= 1'b0;
            ptr_reg <= 8'h00;
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
        end
        else if (start_cond)
        begin
            state_reg <= CCR_ST_ADDR;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (stop_cond)
        begin
            state_reg <= CCR_ST_IGNORE;
            sda_oe <= 1'b0;
        end
        else if (state_reg != CCR_ST_IGNORE)
        begin
            if (scl_rise && !ack_phase_reg)
            begin
                shift_reg <= {shift_reg[6:0], sda_in};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_rise && ack_phase_reg && rw_reg
                     && state_reg == CCR_ST_DATA)
                nack_reg <= sda_in;
            if (scl_fall)
            begin
                if (!ack_phase_reg && bit_cnt_reg == 4'h8)
                begin
                    ack_phase_reg <= 1'b1;
                    bit_cnt_reg <= 4'h0;
                    sda_oe <= 1'b0;
                    case (state_reg)
                        CCR_ST_ADDR:
                        begin
                            if (shift_reg[7:1] == CCR_I2C_ADDR)
                            begin
                                rw_reg <= shift_reg[0];
                                sda_oe <= 1'b1;
                                sda_out <= 1'b0;
                            end
                            else
                                state_reg <= CCR_ST_IGNORE;
                        end
                        CCR_ST_REG:
                        begin
                            // undefined register: nack and go idle
                            if (shift_reg <= CCR_OFS_LAST)
                            begin
                                ptr_reg <= shift_reg;
                                sda_oe <= 1'b1;
                                sda_out <= 1'b0;
                            end
                            else
                                state_reg <= CCR_ST_IGNORE;
                        end
                        CCR_ST_DATA:
                        begin
                            if (!rw_reg)
                            begin
                                sda_oe <= 1'b1;
                                sda_out <= 1'b0;
                                ptr_reg <= ptr_reg + 8'h1;
                            end
                        end
                        default: state_reg <= CCR_ST_IGNORE;
                    endcase
                end
                else if (ack_phase_reg)
                begin
                    ack_phase_reg <= 1'b0;
                    sda_oe <= 1'b0;
                    if (state_reg == CCR_ST_ADDR)
                        state_reg <= rw_reg ? CCR_ST_DATA : CCR_ST_REG;
                    else if (state_reg == CCR_ST_REG)
                        state_reg <= CCR_ST_DATA;
                    else if (rw_reg && nack_reg)
                        state_reg <= CCR_ST_IGNORE;
                    else if (rw_reg)
                        ptr_reg <= ptr_reg + 8'h1;
                    // read data driven msb first, open drain
                    if (rw_reg && (state_reg == CCR_ST_ADDR
                        || (state_reg == CCR_ST_DATA && !nack_reg)))
                    begin
                        shift_reg <= rd_byte;
                        sda_oe <= !rd_byte[7];
                        sda_out <= 1'b0;
                    end
                end
                else if (rw_reg && state_reg == CCR_ST_DATA)
                begin
                    // rise already rotated the byte: next bit is on top
                    sda_oe <= !shift_reg[7];
                    sda_out <= 1'b0;
                end
            end
        end
    end

    // write lands when the eighth data bit has been shifted in
    assign wr_strobe = (state_reg == CCR_ST_DATA) && !rw_reg && scl_fall
        && !ack_phase_reg && bit_cnt_reg == 4'h8 && !start_cond
        && !stop_cond;
    assign wr_data = shift_reg;

    assign detection_start = (wr_strobe && ptr_reg == CCR_OFS_ADC_DETECT
        && wr_data[CCR_B_FORCE_DET])
        || (power_plugged && !plug_q_reg && r2_reg[CCR_B_AUTO_DET]);
    assign watchdog_restart = r3_reg[CCR_B_WD_KICK];

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            plug_q_reg <= 1'b0;
        else
            plug_q_reg <= power_plugged;
    end

    // continuous conversion tick every second
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !r2_reg[CCR_B_ADC_RATE])
            rate_cnt_reg <= 32'h0;
        else if (rate_cnt_reg == 32'(ADC_PERIOD_CYC - 1))
            rate_cnt_reg <= 32'h0;
        else
            rate_cnt_reg <= rate_cnt_reg + 32'h1;
    end
    assign adc_start = (wr_strobe && ptr_reg == CCR_OFS_ADC_DETECT
        && wr_data[CCR_B_ADC_GO] && !r2_reg[CCR_B_ADC_RATE])
        || (r2_reg[CCR_B_ADC_RATE] && rate_cnt_reg == 32'h0);

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            det_busy_reg <= 1'b0;
            adc_busy_reg <= 1'b0;
        end
        else
        begin
            if (detection_start)
                det_busy_reg <= 1'b1;
            else if (detection_done)
                det_busy_reg <= 1'b0;
            if (adc_start)
                adc_busy_reg <= 1'b1;
            else if (adc_done)
                adc_busy_reg <= 1'b0;
        end
    end

    // register reset, watchdog reset, host write and device updates
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || register_reset)
        begin
            r0_reg <= CCR_RST_REG0;
            r1_reg <= CCR_RST_REG1;
            r2_reg <= CCR_RST_REG2;
            r3_reg <= CCR_RST_REG3;
        end
        else if (watchdog_expired)
        begin
            r0_reg <= (r0_reg & CCR_WD_KEEP0) | (CCR_RST_REG0 & ~CCR_WD_KEEP0);
            r1_reg <= (r1_reg & CCR_WD_KEEP1) | (CCR_RST_REG1 & ~CCR_WD_KEEP1);
            r2_reg <= (r2_reg & CCR_WD_KEEP2) | (CCR_RST_REG2 & ~CCR_WD_KEEP2);
            r3_reg <= (r3_reg & CCR_WD_KEEP3) | (CCR_RST_REG3 & ~CCR_WD_KEEP3);
        end
        else
        begin
            if (wr_strobe && ptr_reg == CCR_OFS_INPUT_SOURCE_CONTROL)
                r0_reg <= wr_data;
            else if (detection_done)
                r0_reg[5:0] <= source_select ? CCR_LIM_500MA
                                             : CCR_LIM_3250MA;
            if (wr_strobe && ptr_reg == CCR_OFS_BOOST_TEMP)
                r1_reg <= wr_data;
            if (wr_strobe && ptr_reg == CCR_OFS_ADC_DETECT)
            begin
                r2_reg[CCR_B_ADC_RATE] <= wr_data[CCR_B_ADC_RATE];
                if (!r3_reg[CCR_B_BOOST_EN])
                    r2_reg[CCR_B_BOOST_FSEL] <= wr_data[CCR_B_BOOST_FSEL];
                r2_reg[4:0] <= wr_data[4:0];
            end
            else if (detection_done)
                r2_reg[CCR_B_FORCE_DET] <= 1'b0;
            // start bit mirrors activity, so a late write cannot clear it
            r2_reg[CCR_B_ADC_GO] <= adc_start || detection_start
                || (adc_busy_reg && !adc_done)
                || (det_busy_reg && !detection_done);
            if (wr_strobe && ptr_reg == CCR_OFS_CHARGE_BOOST_WD)
                r3_reg <= wr_data;
            else
                r3_reg[CCR_B_WD_KICK] <= 1'b0;
        end
    end

    assign high_impedance_enable = r0_reg[CCR_B_HIZ];
    assign applied_current_limit = (r0_reg[CCR_B_LIM_PIN]
        && current_limit_pin < r0_reg[5:0]) ? current_limit_pin
        : r0_reg[5:0];
    assign boost_hot_threshold = r1_reg[7:6];
    assign boost_thermal_protect = r1_reg[7:6] != CCR_HOT_THR_OFF;
    assign boost_cold_threshold = r1_reg[CCR_B_COLD_THR];
    assign vin_raw = input_voltage_base_mv + (16'(r1_reg[4:0])
        * CCR_OFS_LSB_MV << input_above_6v);
    assign input_voltage_limit_mv = vin_raw < CCR_VIN_MIN_MV ? CCR_VIN_MIN_MV
        : vin_raw > CCR_VIN_MAX_MV ? CCR_VIN_MAX_MV : vin_raw;
    assign adc_conversion_rate = r2_reg[CCR_B_ADC_RATE];
    assign boost_frequency_select = r2_reg[CCR_B_BOOST_FSEL];
    assign current_optimizer_enable = r2_reg[CCR_B_ICO];
    assign auto_source_detection_enable = r2_reg[CCR_B_AUTO_DET];
    assign battery_load_enable = r3_reg[CCR_B_BAT_LOAD];
    assign boost_output_enable = r3_reg[CCR_B_BOOST_EN];
    assign charge_enable = r3_reg[CCR_B_CHG_EN];
    assign minimum_system_voltage = r3_reg[3:1];
    assign min_battery_select = r3_reg[CCR_B_MIN_VBAT];

    kick_clears_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        r3_reg[CCR_B_WD_KICK] && !wr_strobe |=> !r3_reg[CCR_B_WD_KICK])
        else $error("kick bit did not self clear");
    freq_locked_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        r3_reg[CCR_B_BOOST_EN] && !register_reset && !watchdog_expired
        |=> $stable(r2_reg[CCR_B_BOOST_FSEL]))
        else $error("boost frequency changed in boost");
    start_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        adc_start && !register_reset && !watchdog_expired
        |=> r2_reg[CCR_B_ADC_GO])
        else $error("start bit not set during conversion");
    det_result_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        detection_done && !register_reset && !watchdog_expired && !wr_strobe
        |=> r0_reg[5:0] == ($past(source_select) ? 6'h08 : 6'h3f))
        else $error("detection result not loaded");
    wd_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        watchdog_expired && !register_reset
        |=> r0_reg[5:0] == $past(r0_reg[5:0]) && r3_reg[CCR_B_CHG_EN]
            && !r3_reg[CCR_B_BOOST_EN])
        else $error("watchdog expiry handling wrong");
    vin_clamp_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        input_voltage_limit_mv >= 16'd3900
        && input_voltage_limit_mv <= 16'd15300)
        else $error("input voltage limit out of range");
    limit_min_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        applied_current_limit <= r0_reg[5:0])
        else $error("applied limit above register");
    reg_reset_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        register_reset |=> r0_reg == 8'h08 && r2_reg[7:1] == 7'h08
        && r3_reg == 8'h1a)
        else $error("register reset values wrong");
endmodule

// ### sim/ccr_i2c_host.sv
module ccr_i2c_host (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl_out,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 100ps;
    // quarter bit time, slow enough for the slave's synchronous sampling
    int qtr = 4;
    initial
    begin
        scl_out = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wait_q();
        repeat (qtr) @(posedge clk_sys);
        #1;
    endtask
    // also a repeated start: sda is released before scl rises
    task automatic start_cond();
        sda_low = 1'b0;
        wait_q();
        scl_out = 1'b1;
        wait_q();
        sda_low = 1'b1;
        wait_q();
        scl_out = 1'b0;
        wait_q();
    endtask
    task automatic stop_cond();
        sda_low = 1'b1;
        wait_q();
        scl_out = 1'b1;
        wait_q();
        sda_low = 1'b0;
        wait_q();
    endtask
    // data changes only while scl is low, sampled mid high phase
    task automatic clk_bit(input logic b, output logic r);
        sda_low = ~b;
        wait_q();
        scl_out = 1'b1;
        wait_q();
        r = sda_line;
        wait_q();
        scl_out = 1'b0;
        wait_q();
    endtask
    task automatic xfer(input logic [7:0] d, input logic m_ack,
                        output logic [7:0] r, output logic s_ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            clk_bit(d[i], r[i]);
        clk_bit(~m_ack, b);
        s_ack = ~b;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] rg,
                      input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k1, k2, k3;
        start_cond();
        xfer({a, 1'b0}, 1'b0, r, k1);
        xfer(rg, 1'b0, r, k2);
        xfer(d, 1'b0, r, k3);
        stop_cond();
        ok = k1 & k2 & k3;
    endtask
    // single read ends with a master nack, as the slave expects
    task automatic rd(input logic [6:0] a, input logic [7:0] rg,
                      output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k1, k2, k3, kx;
        start_cond();
        xfer({a, 1'b0}, 1'b0, r, k1);
        xfer(rg, 1'b0, r, k2);
        start_cond();
        xfer({a, 1'b1}, 1'b0, r, k3);
        xfer(8'hff, 1'b0, d, kx);
        stop_cond();
        ok = k1 & k2 & k3;
    endtask
endmodule

// ### sim/charger_config_regs_0_to_3_bench.sv
module charger_config_regs_0_to_3_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] DFLT [4] = '{8'h08, 8'h06, 8'h11, 8'h1a};
    localparam logic [7:0] KEEP [4] = '{8'h3f, 8'h1f, 8'h1d, 8'h0e};
    logic clk_sys, resetn, scl, sda_low, sda_out, sda_oe, sda_line;
    logic register_reset, watchdog_expired, source_select, power_plugged;
    logic detection_done, adc_done, input_above_6v, watchdog_restart;
    logic detection_start, adc_start, high_impedance_enable;
    logic boost_thermal_protect, boost_cold_threshold, adc_conversion_rate;
    logic boost_frequency_select, current_optimizer_enable;
    logic auto_source_detection_enable, battery_load_enable;
    logic boost_output_enable, charge_enable, min_battery_select;
    logic [1:0] boost_hot_threshold;
    logic [2:0] minimum_system_voltage;
    logic [5:0] current_limit_pin, applied_current_limit;
    logic [15:0] input_voltage_base_mv, input_voltage_limit_mv;
    logic [7:0] m [4];
    logic [7:0] rd_v;
    logic ok;
    int error_cnt = 0;
    int checks_done = 0;
    int n_det = 0;
    int n_adc = 0;
    int n_wd = 0;
    int base;
    // open-drain wire with pull-up
    assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
    ccr_regs #(.ADC_PERIOD_CYC(20)) dut_u (
        .clk_sys, .resetn, .scl_in(scl), .sda_in(sda_line), .sda_out,
        .sda_oe, .register_reset, .watchdog_expired, .source_select,
        .power_plugged, .detection_done, .adc_done, .current_limit_pin,
        .input_above_6v, .input_voltage_base_mv, .watchdog_restart,
        .detection_start, .adc_start, .high_impedance_enable,
        .applied_current_limit, .boost_hot_threshold,
        .boost_thermal_protect, .boost_cold_threshold,
        .input_voltage_limit_mv, .adc_conversion_rate,
        .boost_frequency_select, .current_optimizer_enable,
        .auto_source_detection_enable, .battery_load_enable,
        .boost_output_enable, .charge_enable, .minimum_system_voltage,
        .min_battery_select
    );
    ccr_i2c_host host_u (.clk_sys, .sda_line, .scl_out(scl), .sda_low);
    initial
    begin
        clk_sys = 1'b0;
        forever
            #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        n_det <= n_det + int'(detection_start === 1'b1);
        n_adc <= n_adc + int'(adc_start === 1'b1);
        n_wd <= n_wd + int'(watchdog_restart === 1'b1);
    end
    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk_reg(string what, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic chk_out(string what, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(2);
    endtask
    task automatic rd_chk(int a);
        host_u.rd(7'h6b, 8'(a), rd_v, ok);
        chk_out("read ack", 16'h1, {15'h0, ok});
        chk_reg($sformatf("register %0d", a), m[a], rd_v);
    endtask
    // model of a host write: protected bits keep their old value
    task automatic wr_m(int a, logic [7:0] d);
        host_u.wr(7'h6b, 8'(a), d, ok);
        chk_out("write ack", 16'h1, {15'h0, ok});
        if (a == 2 && m[3][5])
            d[5] = m[2][5];
        if (a == 2 && m[2][6])
            d[7] = m[2][7];
        if (a == 3)
            d[6] = 1'b0;
        m[a] = d;
    endtask
    task automatic chk_outs();
        int lim;
        int v;
        current_limit_pin = 6'($urandom);
        input_above_6v = 1'($urandom);
        input_voltage_base_mv = 16'($urandom_range(2000, 14000));
        tick(2);
        lim = (m[0][6] && current_limit_pin < m[0][5:0]) ?
              current_limit_pin : m[0][5:0];
        chk_out("current limit", 16'(lim), 16'(applied_current_limit));
        v = input_voltage_base_mv +
            m[1][4:0] * 100 * (input_above_6v ? 2 : 1);
        v = v < 3900 ? 3900 : (v > 15300 ? 15300 : v);
        chk_out("voltage limit", 16'(v), input_voltage_limit_mv);
        chk_out("fields", {m[0][7], m[1][7:6], m[1][7:6] != 2'b11, m[1][5],
            m[2][6:4], m[2][0], m[3][7], m[3][5:0]}, {high_impedance_enable,
            boost_hot_threshold, boost_thermal_protect, boost_cold_threshold,
            adc_conversion_rate, boost_frequency_select,
            current_optimizer_enable, auto_source_detection_enable,
            battery_load_enable, boost_output_enable, charge_enable,
            minimum_system_voltage, min_battery_select});
    endtask
    task automatic rd_all();
        for (int a = 0; a < 4; a++)
            rd_chk(a);
        chk_outs();
    endtask
    initial
    begin
        resetn = 1'b0;
        {register_reset, watchdog_expired, source_select} = 3'b000;
        {power_plugged, detection_done, adc_done} = 3'b000;
        current_limit_pin = 6'h00;
        input_above_6v = 1'b0;
        input_voltage_base_mv = 16'h0000;
        base = $urandom(69380);
        m = DFLT;
        tick(4);
        resetn = 1'b1;
        rd_all();
        $display("done: defaults");
        host_u.wr(7'h6a, 8'h00, 8'hff, ok);
        chk_out("foreign address ack", 16'h0, {15'h0, ok});
        host_u.rd(7'h6b, 8'h04, rd_v, ok);
        chk_out("unmapped register ack", 16'h0, {15'h0, ok});
        rd_chk(0);
        $display("done: refusals");
        for (int i = 0; i < 3; i++)
        begin
            wr_m(3, 8'($urandom) & 8'h9f | (i == 1 ? 8'h20 : 8'h00));
            wr_m(2, 8'($urandom) & 8'h1d | {2'b0, ~m[2][5], 5'b0});
            wr_m(1, 8'($urandom));
            wr_m(0, 8'($urandom));
            rd_all();
        end
        $display("done: random writes");
        wr_m(3, 8'hbf);
        wr_m(2, 8'h3d);
        wr_m(1, 8'hff);
        wr_m(0, 8'hff);
        pulse(watchdog_expired);
        for (int a = 0; a < 4; a++)
            m[a] = m[a] & KEEP[a] | DFLT[a] & ~KEEP[a];
        rd_all();
        pulse(register_reset);
        m = DFLT;
        rd_all();
        $display("done: watchdog and register reset");
        base = n_wd;
        wr_m(3, m[3] | 8'h40);
        chk_out("kick pulses", 16'h1, 16'(n_wd - base));
        rd_chk(3);
        $display("done: watchdog kick");
        base = n_adc;
        wr_m(2, 8'h91);
        chk_out("adc starts", 16'h1, 16'(n_adc - base));
        rd_chk(2);
        pulse(adc_done);
        m[2][7] = 1'b0;
        rd_chk(2);
        base = n_adc;
        wr_m(2, 8'h51);
        m[2][7] = 1'b1;
        chk_out("continuous start", 16'h1, 16'(n_adc > base));
        wr_m(2, 8'h51);
        rd_chk(2);
        wr_m(2, 8'h11);
        pulse(adc_done);
        m[2][7] = 1'b0;
        rd_chk(2);
        $display("done: adc control");
        wr_m(0, 8'h05);
        base = n_det;
        source_select = 1'b1;
        wr_m(2, 8'h13);
        chk_out("forced detection", 16'h1, 16'(n_det - base));
        m[2][7] = 1'b1;
        rd_chk(2);
        pulse(detection_done);
        m[0][5:0] = 6'h08;
        rd_chk(0);
        source_select = 1'b0;
        power_plugged = 1'b1;
        tick(3);
        chk_out("plug detection", 16'h2, 16'(n_det - base));
        pulse(detection_done);
        m[0][5:0] = 6'h3f;
        rd_chk(0);
        wr_m(2, 8'h10);
        power_plugged = 1'b0;
        tick(3);
        power_plugged = 1'b1;
        tick(3);
        chk_out("plug without auto", 16'h2, 16'(n_det - base));
        chk_outs();
        $display("done: source detection");
        conclude();
    end
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        error_cnt++;
        $display("unexpected run length: expected finish, seen hang");
        conclude();
    end
endmodule
